// *** rtl/oss_pkg.sv ***
// Constants shared by the output synchronisation supervisor
package oss_pkg;

    // ------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 50_000_000;
    localparam int unsigned NS_PER_S    = 1_000_000_000;
    localparam logic [31:0] CLK_STEP_NS = 32'(NS_PER_S / CLK_FREQ_HZ);
    localparam logic [31:0] NS_MAX      = 32'hffff_ffff;

    // ------------------------------------------------------------
    // Register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam int          IDX_W           = 6;
    localparam logic [5:0]  IDX_ENTRY_COUNT = 6'h00;
    localparam logic [5:0]  IDX_SOURCE      = 6'h01;
    localparam logic [5:0]  IDX_PERIOD      = 6'h02;
    localparam logic [5:0]  IDX_SHIFT       = 6'h03;
    localparam logic [5:0]  IDX_CAPS        = 6'h04;
    localparam logic [5:0]  IDX_MIN_PERIOD  = 6'h05;
    localparam logic [5:0]  IDX_SPACING     = 6'h06;
    localparam logic [5:0]  IDX_COMMAND     = 6'h08;
    localparam logic [5:0]  IDX_DELAY       = 6'h09;
    localparam logic [5:0]  IDX_MISSED      = 6'h0b;
    localparam logic [5:0]  IDX_OVERRUN     = 6'h0c;
    localparam logic [5:0]  IDX_SHORT       = 6'h0d;
    localparam logic [5:0]  IDX_LATE        = 6'h20;
    localparam logic [5:0]  IDX_IRQ_STATUS  = 6'h21;
    localparam logic [5:0]  IDX_IRQ_MASK    = 6'h22;

    // ------------------------------------------------------------
    // Fixed values, reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0]  ENTRY_COUNT_VAL = 8'h20;
    localparam logic [15:0] SOURCE_RESET    = 16'h0001;
    localparam logic [15:0] CAPS_VAL        = 16'hc007;
    localparam logic [15:0] CMD_START       = 16'h0001;
    localparam logic [15:0] CMD_RESET       = 16'h0000;
    localparam logic [15:0] MODE_FREE       = 16'h0000;
    localparam logic [15:0] MODE_BUF        = 16'h0001;
    localparam logic [15:0] MODE_FIRST_SYNC_PULSE      = 16'h0002;
    localparam logic [15:0] MODE_SECOND_SYNC_PULSE      = 16'h0003;
    localparam logic [15:0] CNT_MAX         = 16'hffff;
    localparam logic [15:0] CNT_ONE         = 16'h0001;

    // Interrupt status / mask bit positions
    localparam int          IRQ_W       = 4;
    localparam int          IRQ_MISSED  = 0;
    localparam int          IRQ_OVERRUN = 1;
    localparam int          IRQ_SHORT   = 2;
    localparam int          IRQ_LATE    = 3;

    // Elapsed-time trackers
    localparam int          NUM_TMR   = 4;
    localparam int          TMR_FIRST_SYNC_PULSE = 0;
    localparam int          TMR_SECOND_SYNC_PULSE = 1;
    localparam int          TMR_TRIG  = 2;
    localparam int          TMR_BUF   = 3;

    // AHB-Lite
    localparam int          HTRANS_ACTIVE_BIT = 1;
    localparam logic        HRESP_OKAY        = 1'b0;
    localparam int          HADDR_IDX_LSB     = 2;

endpackage

// *** rtl/oss_supervisor.sv ***
// Output synchronisation supervisor with AHB-Lite register slave
`timescale 1ns/1ps

module oss_supervisor (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        first_sync_pulse,
    input  wire logic        second_sync_pulse,
    input  wire logic        buffer_write_event,
    input  wire logic        run_state,
    input  wire logic        cycle_work_done,
    output logic             output_apply,
    output logic             irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic                       wr_pend_q, wr_pend_d;
    logic [oss_pkg::IDX_W-1:0]  wr_idx_q,  wr_idx_d;
    logic [31:0]                rdata_q,   rdata_d;
    logic [15:0]                source_q,  source_d;
    logic [31:0]                period_q,  period_d;
    logic [15:0]                command_q, command_d;
    logic [oss_pkg::IRQ_W-1:0]  status_q,  status_d;
    logic [oss_pkg::IRQ_W-1:0]  mask_q,    mask_d;
    logic [1:0]                 meta_q, mid_q, last_q, level_q, level_d;
    logic [1:0]                 pulse_rise;
    logic [31:0]                free_acc_q, free_acc_d;
    logic [31:0]                tmr_q [oss_pkg::NUM_TMR];
    logic [31:0]                tmr_d [oss_pkg::NUM_TMR];
    logic [oss_pkg::NUM_TMR-1:0] tmr_restart;
    logic                       apply_q, apply_d;
    logic                       busy_q, busy_d;
    logic                       buf_seen_q, buf_seen_d;
    logic [31:0]                shift_q, shift_d;
    logic [31:0]                min_period_q, min_period_d;
    logic [31:0]                spacing_q, spacing_d;
    logic [31:0]                delay_q, delay_d;
    logic [15:0]                missed_q, missed_d;
    logic [15:0]                overrun_q, overrun_d;
    logic [15:0]                short_q, short_d;
    logic                       late_q, late_d;
    logic                       accept, wr_now, start_meas, meas_on;
    logic                       dc_mode, free_fire, trig;
    logic                       ev_missed, ev_overrun, ev_short;
    logic [oss_pkg::IDX_W-1:0]  acc_idx;
    logic [oss_pkg::IRQ_W-1:0]  irq_events;

    function automatic logic [31:0] ns_add(input logic [31:0] a);
        ns_add = (a > oss_pkg::NS_MAX - oss_pkg::CLK_STEP_NS)
               ? oss_pkg::NS_MAX : a + oss_pkg::CLK_STEP_NS;
    endfunction

    function automatic logic [15:0] cnt_inc(input logic [15:0] c,
                                            input logic        ev);
        // Saturating count
        // no wrap
        cnt_inc = (ev && c != oss_pkg::CNT_MAX) ? c + oss_pkg::CNT_ONE : c;
    endfunction

    function automatic logic [31:0] keep_max(input logic [31:0] cur,
                                             input logic [31:0] cand,
                                             input logic        ev);
        keep_max = (ev && cand > cur) ? cand : cur;
    endfunction

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    assign accept  = hsel & hready & htrans[oss_pkg::HTRANS_ACTIVE_BIT];
    assign acc_idx = haddr[oss_pkg::HADDR_IDX_LSB +: oss_pkg::IDX_W];
    assign wr_now  = wr_pend_q;

    always_comb begin
        wr_pend_d = accept & hwrite;
        wr_idx_d  = accept ? acc_idx : wr_idx_q;
        rdata_d   = rdata_q;
        if (accept && !hwrite) begin
            rdata_d = 32'h0000_0000;
            case (acc_idx)
                oss_pkg::IDX_ENTRY_COUNT:
                    rdata_d[7:0] = oss_pkg::ENTRY_COUNT_VAL;
                oss_pkg::IDX_SOURCE:      rdata_d[15:0] = source_q;
                oss_pkg::IDX_PERIOD:      rdata_d = period_q;
                oss_pkg::IDX_SHIFT:       rdata_d = shift_q;
                oss_pkg::IDX_CAPS:        rdata_d[15:0] = oss_pkg::CAPS_VAL;
                oss_pkg::IDX_MIN_PERIOD:  rdata_d = min_period_q;
                oss_pkg::IDX_SPACING:     rdata_d = spacing_q;
                oss_pkg::IDX_COMMAND:     rdata_d[15:0] = command_q;
                oss_pkg::IDX_DELAY:       rdata_d = delay_q;
                oss_pkg::IDX_MISSED:      rdata_d[15:0] = missed_q;
                oss_pkg::IDX_OVERRUN:     rdata_d[15:0] = overrun_q;
                oss_pkg::IDX_SHORT:       rdata_d[15:0] = short_q;
                oss_pkg::IDX_LATE:        rdata_d[0] = late_q;
                oss_pkg::IDX_IRQ_STATUS:  rdata_d[oss_pkg::IRQ_W-1:0] = status_q;
                oss_pkg::IDX_IRQ_MASK:    rdata_d[oss_pkg::IRQ_W-1:0] = mask_q;
                default:                  rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= '0;
            rdata_q   <= 32'h0000_0000;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_idx_q  <= wr_idx_d;
            rdata_q   <= rdata_d;
        end
    end

    // Zero wait states: a read in a write's data phase sees the old value
    assign hrdata    = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = oss_pkg::HRESP_OKAY;

    // ------------------------------------------------------------
    // Software-written control
    // ------------------------------------------------------------
    // A repeated start clears the values again
    // start on write of one
    assign start_meas = wr_now && wr_idx_q == oss_pkg::IDX_COMMAND
                        && hwdata[15:0] == oss_pkg::CMD_START;
    assign meas_on    = command_q == oss_pkg::CMD_START;

    always_comb begin
        source_d  = source_q;
        period_d  = period_q;
        command_d = command_q;
        mask_d    = mask_q;
        // Hardware set wins over a write-one clear
        status_d  = status_q | irq_events;
        if (wr_now) begin
            case (wr_idx_q)
                oss_pkg::IDX_SOURCE:     source_d  = hwdata[15:0];
                oss_pkg::IDX_PERIOD:     period_d  = hwdata;
                oss_pkg::IDX_COMMAND:    command_d = hwdata[15:0];
                oss_pkg::IDX_IRQ_MASK:   mask_d    = hwdata[oss_pkg::IRQ_W-1:0];
                oss_pkg::IDX_IRQ_STATUS: status_d  = (status_q
                    & ~hwdata[oss_pkg::IRQ_W-1:0]) | irq_events;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            source_q  <= oss_pkg::SOURCE_RESET;
            period_q  <= 32'h0000_0000;
            command_q <= oss_pkg::CMD_RESET;
            status_q  <= '0;
            mask_q    <= '0;
        end else begin
            source_q  <= source_d;
            period_q  <= period_d;
            command_q <= command_d;
            status_q  <= status_d;
            mask_q    <= mask_d;
        end
    end

    assign irq = |(status_q & mask_q);

    // ------------------------------------------------------------
    // Sync pulse inputs, three-stage with agreement filter
    // ------------------------------------------------------------
    // Edge taken only when stages two and three agree, so glitches are lost
    // A pulse must stay low for two clocks before it can rise again
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            level_d[i]    = (mid_q[i] == last_q[i]) ? last_q[i] : level_q[i];
            pulse_rise[i] = level_d[i] & ~level_q[i];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q  <= 2'b00;
            mid_q   <= 2'b00;
            last_q  <= 2'b00;
            level_q <= 2'b00;
        end else begin
            meta_q  <= {second_sync_pulse, first_sync_pulse};
            mid_q   <= meta_q;
            last_q  <= mid_q;
            level_q <= level_d;
        end
    end

    // ------------------------------------------------------------
    // Trigger selection and local timer
    // ------------------------------------------------------------
    // Both pulse sources count as clock-synchronised mode
    assign dc_mode = source_q == oss_pkg::MODE_FIRST_SYNC_PULSE
                  || source_q == oss_pkg::MODE_SECOND_SYNC_PULSE;

    always_comb begin
        free_fire  = 1'b0;
        free_acc_d = 32'h0000_0000;
        // Restart after firing rounds the period up to whole clocks
        // free-run period in ns
        if (source_q == oss_pkg::MODE_FREE && period_q != 32'h0000_0000) begin
            if (ns_add(free_acc_q) >= period_q) begin
                free_fire = 1'b1;
            end else begin
                free_acc_d = ns_add(free_acc_q);
            end
        end
        case (source_q)
            oss_pkg::MODE_FREE:  trig = free_fire;
            oss_pkg::MODE_BUF:   trig = buffer_write_event;
            oss_pkg::MODE_FIRST_SYNC_PULSE: trig = pulse_rise[0];
            oss_pkg::MODE_SECOND_SYNC_PULSE: trig = pulse_rise[1];
            default:             trig = 1'b0;
        endcase
        apply_d     = trig;
        // A new cycle keeps the core busy even if work ends this cycle
        busy_d      = trig | (busy_q & ~cycle_work_done);
        buf_seen_d  = buffer_write_event | (buf_seen_q & ~pulse_rise[0]);
        // Trackers restart at one step so the event cycle counts as 20 ns
        tmr_restart = {buffer_write_event, trig, pulse_rise[1], pulse_rise[0]};
        for (int t = 0; t < oss_pkg::NUM_TMR; t++) begin
            tmr_d[t] = tmr_restart[t] ? oss_pkg::CLK_STEP_NS : ns_add(tmr_q[t]);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            free_acc_q <= 32'h0000_0000;
            apply_q    <= 1'b0;
            busy_q     <= 1'b0;
            buf_seen_q <= 1'b0;
            for (int t = 0; t < oss_pkg::NUM_TMR; t++) begin
                tmr_q[t] <= 32'h0000_0000;
            end
        end else begin
            free_acc_q <= free_acc_d;
            apply_q    <= apply_d;
            busy_q     <= busy_d;
            buf_seen_q <= buf_seen_d;
            for (int t = 0; t < oss_pkg::NUM_TMR; t++) begin
                tmr_q[t] <= tmr_d[t];
            end
        end
    end

    assign output_apply = apply_q;

    // ------------------------------------------------------------
    // Timing measurement
    // ------------------------------------------------------------
    // Values are sampled at apply or at work done, never in between
    always_comb begin
        shift_d      = shift_q;
        min_period_d = min_period_q;
        spacing_d    = spacing_q;
        delay_d      = delay_q;
        if (start_meas) begin
            shift_d      = 32'h0000_0000;
            min_period_d = 32'h0000_0000;
            spacing_d    = 32'h0000_0000;
            delay_d      = 32'h0000_0000;
        end else if (meas_on) begin
            shift_d = keep_max(shift_q, tmr_q[oss_pkg::TMR_FIRST_SYNC_PULSE],
                               apply_q & dc_mode);
            delay_d = keep_max(delay_q, tmr_q[oss_pkg::TMR_SECOND_SYNC_PULSE],
                               apply_q & dc_mode);
            min_period_d = keep_max(min_period_q, tmr_q[oss_pkg::TMR_TRIG],
                                    cycle_work_done & busy_q);
            spacing_d = keep_max(spacing_q, tmr_q[oss_pkg::TMR_BUF],
                                 cycle_work_done & dc_mode);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_q      <= 32'h0000_0000;
            min_period_q <= 32'h0000_0000;
            spacing_q    <= 32'h0000_0000;
            delay_q      <= 32'h0000_0000;
        end else begin
            shift_q      <= shift_d;
            min_period_q <= min_period_d;
            spacing_q    <= spacing_d;
            delay_q      <= delay_d;
        end
    end

    // ------------------------------------------------------------
    // Error counters and late flag
    // ------------------------------------------------------------
    // Missed window restarts at each first-pulse rise
    // missed buffer event
    assign ev_missed  = pulse_rise[0] & dc_mode & run_state & ~buf_seen_q;
    assign ev_overrun = trig & run_state & busy_q;
    assign ev_short   = pulse_rise[1] & dc_mode
                      & (tmr_q[oss_pkg::TMR_FIRST_SYNC_PULSE] < spacing_q);

    always_comb begin
        // Counters hold at all ones until reset
        missed_d  = cnt_inc(missed_q, ev_missed);
        overrun_d = cnt_inc(overrun_q, ev_overrun);
        short_d   = cnt_inc(short_q, ev_short);
        late_d    = dc_mode ? (trig ? busy_q : late_q) : 1'b0;
        irq_events = '0;
        irq_events[oss_pkg::IRQ_MISSED]  = ev_missed;
        irq_events[oss_pkg::IRQ_OVERRUN] = ev_overrun;
        irq_events[oss_pkg::IRQ_SHORT]   = ev_short;
        irq_events[oss_pkg::IRQ_LATE]    = dc_mode & trig & busy_q;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            missed_q  <= 16'h0000;
            overrun_q <= 16'h0000;
            short_q   <= 16'h0000;
            late_q    <= 1'b0;
        end else begin
            missed_q  <= missed_d;
            overrun_q <= overrun_d;
            short_q   <= short_d;
            late_q    <= late_d;
        end
    end

endmodule

// *** tb/oss_supervisor_sva.sv ***
// Port-level checker for the output synchronisation supervisor
`timescale 1ns/1ps
module oss_supervisor_sva (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        buffer_write_event,
    input wire logic        output_apply,
    input wire logic        irq
);
    logic        rd_q, rd_d, wr_q, wr_d;
    logic [5:0]  idx_q, idx_d;
    logic [15:0] mode_q, mode_d, cmd_q, cmd_d;
    logic [31:0] per_q, per_d;
    logic [3:0]  msk_q, msk_d;

    // Shadow of the source, period, command and mask registers, taken from bus traffic
    always_comb begin
        rd_d   = hsel && hready && htrans[1] && !hwrite;
        wr_d   = hsel && hready && htrans[1] && hwrite;
        idx_d  = (rd_d || wr_d) ? haddr[7:2] : idx_q;
        mode_d = (wr_q && idx_q == oss_pkg::IDX_SOURCE) ? hwdata[15:0] : mode_q;
        cmd_d  = (wr_q && idx_q == oss_pkg::IDX_COMMAND) ? hwdata[15:0] : cmd_q;
        per_d  = (wr_q && idx_q == oss_pkg::IDX_PERIOD) ? hwdata : per_q;
        msk_d  = (wr_q && idx_q == oss_pkg::IDX_IRQ_MASK) ? hwdata[3:0] : msk_q;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {rd_q, wr_q, idx_q, cmd_q, per_q, msk_q} <= '0;
            mode_q <= oss_pkg::SOURCE_RESET;
        end else begin
            {rd_q, wr_q, idx_q, cmd_q, per_q, msk_q} <=
                {rd_d, wr_d, idx_d, cmd_d, per_d, msk_d};
            mode_q <= mode_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence rd_of(logic [5:0] i);
        rd_q && idx_q == i;
    endsequence

    entry_count_a: assert property (
        rd_of(oss_pkg::IDX_ENTRY_COUNT) |-> hrdata == 32'h0000_0020)
        else $error("entry count read wrong");
    source_read_a: assert property (
        rd_of(oss_pkg::IDX_SOURCE) |-> hrdata == {16'h0000, mode_q})
        else $error("source read wrong");
    buf_apply_a: assert property (
        mode_q == 16'h0001 && buffer_write_event |=> output_apply)
        else $error("buffer event gave no apply");
    period_read_a: assert property (
        rd_of(oss_pkg::IDX_PERIOD) |-> hrdata == per_q)
        else $error("period read wrong");
    free_idle_a: assert property (
        mode_q == 16'h0000 && per_q == 32'h0 |=> !output_apply)
        else $error("apply with zero period");
    caps_word_a: assert property (
        rd_of(oss_pkg::IDX_CAPS) |-> hrdata == 32'h0000_c007)
        else $error("caps read wrong");
    caps_dc_a: assert property (
        rd_of(oss_pkg::IDX_CAPS) |-> hrdata[3:2] == 2'b01)
        else $error("caps sync field wrong");
    cmd_read_a: assert property (
        rd_of(oss_pkg::IDX_COMMAND) |-> hrdata == {16'h0000, cmd_q})
        else $error("command read wrong");
    count_width_a: assert property (
        rd_of(oss_pkg::IDX_MISSED) or rd_of(oss_pkg::IDX_OVERRUN)
        |-> hrdata[31:16] == 16'h0000) else $error("counter too wide");
    late_width_a: assert property (
        rd_of(oss_pkg::IDX_LATE) |-> hrdata[31:1] == 31'h0)
        else $error("late flag too wide");
    irq_mask_a: assert property (
        msk_q == 4'h0 |-> !irq && hreadyout && !hresp)
        else $error("irq while masked or bad response");
endmodule

bind oss_supervisor oss_supervisor_sva chk_u (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .buffer_write_event(buffer_write_event),
    .output_apply(output_apply), .irq(irq));

// *** tb/oss_ahb_master.sv ***
// Bus master model standing in for the network master
`timescale 1ns/1ps
module oss_ahb_master (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            output_sync_supervisor_bench.failures++;
            output_sync_supervisor_bench.print_verdict();
        end
    endtask

    task automatic xfer(input logic [5:0] idx, input bit wr,
                        input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h0;
        wait_ready();
        q = hrdata;
    endtask
endmodule

// *** tb/output_sync_supervisor_bench.sv ***
// Self-checking bench for the output synchronisation supervisor
`timescale 1ns/1ps
module output_sync_supervisor_bench;
    typedef struct {
        logic [5:0]  idx;
        bit          wr;
        logic [31:0] d;
        logic [31:0] e;
    } oss_row_s;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        hsel, hwrite, hreadyout, hresp, irq, output_apply;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        first_sync_pulse = 1'b0, second_sync_pulse = 1'b0;
    logic        buffer_write_event = 1'b0, run_state = 1'b0;
    logic        cycle_work_done = 1'b0;
    int          failures = 0, num_checks = 0, gap;
    oss_row_s    rows [20] = '{
        '{6'h00, 0, 32'h0, 32'h20},
        '{6'h01, 0, 32'h0, 32'h1},
        '{6'h02, 0, 32'h0, 32'h0},
        '{6'h03, 0, 32'h0, 32'h0},
        '{6'h04, 0, 32'h0, 32'hc007},
        '{6'h05, 0, 32'h0, 32'h0},
        '{6'h06, 0, 32'h0, 32'h0},
        '{6'h08, 0, 32'h0, 32'h0},
        '{6'h09, 0, 32'h0, 32'h0},
        '{6'h0b, 0, 32'h0, 32'h0},
        '{6'h0c, 0, 32'h0, 32'h0},
        '{6'h0d, 0, 32'h0, 32'h0},
        '{6'h20, 0, 32'h0, 32'h0},
        '{6'h07, 1, 32'h5a, 32'h0},
        '{6'h04, 1, 32'hffff, 32'hc007},
        '{6'h05, 1, 32'h1234, 32'h0},
        '{6'h02, 1, 32'h87654321, 32'h87654321},
        '{6'h01, 1, 32'h3, 32'h3},
        '{6'h01, 1, 32'h0, 32'h0},
        '{6'h01, 1, 32'h1, 32'h1}};

    oss_ahb_master mst_u (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));
    oss_supervisor dut_u (.clk(clk), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .first_sync_pulse(first_sync_pulse),
        .second_sync_pulse(second_sync_pulse),
        .buffer_write_event(buffer_write_event), .run_state(run_state),
        .cycle_work_done(cycle_work_done), .output_apply(output_apply),
        .irq(irq));

    always #10 clk = ~clk;

    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        logic [31:0] q;
        mst_u.xfer(i, 1'b1, d, q);
    endtask

    task automatic rd(input logic [5:0] i, output logic [31:0] q);
        mst_u.xfer(i, 1'b0, 32'h0, q);
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // Counts cycles up to the next apply pulse
    task automatic wait_apply(output int n);
        n = 0;
        do begin
            tick();
            n++;
        end while (output_apply !== 1'b1 && n < 30);
        if (output_apply !== 1'b1) begin
            failures++;
            print_verdict();
        end
    endtask

    task automatic trig();
        @(posedge clk);
        buffer_write_event <= 1'b1;
        tick();
        buffer_write_event <= 1'b0;
        chk("apply", 32'h1, 32'(output_apply));
    endtask

    task automatic done_pulse();
        @(posedge clk);
        cycle_work_done <= 1'b1;
        @(posedge clk);
        cycle_work_done <= 1'b0;
    endtask

    task automatic pin(input bit sec);
        @(posedge clk);
        if (sec) second_sync_pulse <= 1'b1;
        else first_sync_pulse <= 1'b1;
        wait_apply(gap);
        chk("pin delay", 32'd4, 32'(gap));
        @(posedge clk);
        {first_sync_pulse, second_sync_pulse} <= 2'b00;
        // Low long enough for the filter to see the fall
        repeat (4) @(posedge clk);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].idx, rows[i].d);
            rd(rows[i].idx, v);
            chk($sformatf("reg %h", rows[i].idx), rows[i].e, v);
        end
        for (int m = 2; m < 4; m++) begin
            wr(oss_pkg::IDX_SOURCE, 32'(m));
            pin(m == 3);
        end
        wr(oss_pkg::IDX_PERIOD, 32'd100);
        wr(oss_pkg::IDX_SOURCE, 32'h0);
        wait_apply(gap);
        wait_apply(gap);
        chk("free gap", 32'd5, 32'(gap));
        wr(oss_pkg::IDX_PERIOD, 32'h0);
        wr(oss_pkg::IDX_SOURCE, 32'h1);
        run_state <= 1'b1;
        done_pulse();
        trig();
        done_pulse();
        trig();
        trig();
        rd(oss_pkg::IDX_OVERRUN, v);
        chk("overrun", 32'h1, v);
        chk("irq masked", 32'h0, 32'(irq));
        wr(oss_pkg::IDX_IRQ_MASK, 32'h2);
        #1;
        chk("irq set", 32'h1, 32'(irq));
        wr(oss_pkg::IDX_IRQ_STATUS, 32'h2);
        #1;
        chk("irq clear", 32'h0, 32'(irq));
        wr(oss_pkg::IDX_SOURCE, 32'h2);
        pin(1'b0);
        pin(1'b0);
        rd(oss_pkg::IDX_MISSED, v);
        chk("missed", 32'h1, v);
        rd(oss_pkg::IDX_LATE, v);
        chk("late", 32'h1, v);
        run_state <= 1'b0;
        done_pulse();
        wr(oss_pkg::IDX_SOURCE, 32'h1);
        wr(oss_pkg::IDX_COMMAND, 32'h1);
        trig();
        repeat (2) @(posedge clk);
        done_pulse();
        rd(oss_pkg::IDX_MIN_PERIOD, v);
        chk("min period", 32'd4 * oss_pkg::CLK_STEP_NS, v);
        wr(oss_pkg::IDX_COMMAND, 32'h0);
        trig();
        repeat (6) @(posedge clk);
        done_pulse();
        rd(oss_pkg::IDX_MIN_PERIOD, v);
        chk("stopped", 32'd4 * oss_pkg::CLK_STEP_NS, v);
        wr(oss_pkg::IDX_COMMAND, 32'h1);
        rd(oss_pkg::IDX_MIN_PERIOD, v);
        chk("restart", 32'h0, v);
        wr(oss_pkg::IDX_SOURCE, 32'h2);
        pin(1'b0);
        rd(oss_pkg::IDX_SHIFT, v);
        chk("shift", oss_pkg::CLK_STEP_NS, v);
        done_pulse();
        wr(oss_pkg::IDX_SOURCE, 32'h3);
        pin(1'b1);
        rd(oss_pkg::IDX_SHORT, v);
        chk("short", 32'h1, v);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(oss_pkg::IDX_SOURCE, v);
        chk("source reset", 32'h1, v);
        print_verdict();
    end
endmodule
